/* File: core/ptic_defs.svh */
// Register map, field positions, reset values and frame counts of the threshold slice
`ifndef PTIC_DEFS_SVH
`define PTIC_DEFS_SVH
// Contract
// - Low threshold byte holds threshold bits 7..0, read/write, resets to zero.
// - High threshold byte bits 6..0 hold threshold bits 14..8, bit 7 unused.
// - Both bytes form one right-justified 15-bit unsigned value, hPa times 16.
// - Threshold events only with differential enable and high or low enable set.
// - Interface bit 7 lets the interrupt pin drive while I3C is active.
// - Interface bit 3 adds SDO pull-up, bit 4 SDA pull-up; both reset off.
// - Interface bit 2 disconnects the interrupt pin pull-down; reset keeps it.
// - Interface bit 1 disables the I3C protocol; reset leaves I3C enabled.
// - Interface bit 0 disables I2C; reset leaves SPI and I2C enabled.
// - High enable flags pressure above threshold; low enable flags pressure below it.
// - Compared value is measured pressure minus stored reference pressure.

// Register addresses on the serial port
`define PTIC_ADDR_THS_LOW 7'h0c
`define PTIC_ADDR_THS_HIGH 7'h0d
`define PTIC_ADDR_IF_CTRL 7'h0e

// Reset values
`define PTIC_RST_THS_LOW 8'h00
`define PTIC_RST_THS_HIGH 8'h00
`define PTIC_RST_IF_CTRL 8'h00

// Writable bit masks; masked bits read as zero
`define PTIC_MASK_THS_HIGH 8'h7f
`define PTIC_MASK_IF_CTRL 8'h9f

// Interface control field positions
`define PTIC_BIT_INT_EN_I3C 7
`define PTIC_BIT_SDA_PULLUP_ENABLE 4
`define PTIC_BIT_SDO_PULLUP_ENABLE 3
`define PTIC_BIT_INT_PD_DIS 2
`define PTIC_BIT_I3C_DIS 1
`define PTIC_BIT_I2C_DIS 0

// Threshold encoding: value equals hPa times this factor
`define PTIC_THS_PER_HPA 16
`define PTIC_THS_W 15

// Serial frame: edge index of last command bit and of last data bit
`define PTIC_FRAME_CMD_LAST 4'h7
`define PTIC_FRAME_DATA_LAST 4'hf

// Default pressure word width and shift from pressure LSBs to threshold LSBs
`define PTIC_PRESS_W 24
`define PTIC_PRESS_TO_THS_SHIFT 8

`endif

/* File: core/ptic_pkg.sv */
// Types used by the serial link end; the register core keeps its own state type
package ptic_pkg;

  // Phase of a serial frame
  typedef enum logic [1:0] {
    PH_ADDR = 2'b00,
    PH_WDATA = 2'b01,
    PH_RDATA = 2'b10,
    PH_IDLE = 2'b11
  } ptic_phase_t;

  // Per-frame state, cleared while chip select is high
  typedef struct packed {
    ptic_phase_t phase;
    logic [3:0] cnt;
    logic rd;
    logic [6:0] addr;
    logic [7:0] shift;
    logic sdo;
    logic sdo_oe;
  } ptic_frame_t;

  // State that outlives a frame
  typedef struct packed {
    logic wr_tog;
    logic [6:0] wr_addr;
    logic [7:0] wr_data;
    logic [23:0] bank_s1;
    logic [23:0] bank_s2;
  } ptic_link_t;

endpackage

/* File: core/ptic_spi_link.sv */
// Serial register port end running on the link clock
`include "ptic_defs.svh"

module ptic_spi_link
(
  input wire logic spi_clk_in,
  input wire logic rst_async_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sdi_in,
  input wire logic [23:0] bank_in,
  output logic spi_sdo_out,
  output logic spi_sdo_oe_out,
  output logic wr_tog_out,
  output logic [6:0] wr_addr_out,
  output logic [7:0] wr_data_out
);

  ptic_pkg::ptic_frame_t fq;
  ptic_pkg::ptic_frame_t fd;
  ptic_pkg::ptic_link_t lq;
  ptic_pkg::ptic_link_t ld;
  logic [6:0] cmd_addr;

  // Byte returned for a read address; synced bank, unmapped reads zero
  function automatic logic [7:0] pick(input logic [6:0] a, input logic [23:0] b);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      `PTIC_ADDR_THS_LOW: r = b[7:0];
      `PTIC_ADDR_THS_HIGH: r = b[15:8];
      `PTIC_ADDR_IF_CTRL: r = b[23:16];
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  assign cmd_addr = {fq.addr[5:0], spi_sdi_in};

  // Frame decode: bit 0 read flag, 7 address bits, 8 data bits, MSB first
  always_comb
  begin
    fd = fq;
    ld = lq;
    // Bank words change only after a write lands, so two stages settle them
    ld.bank_s1 = bank_in;
    ld.bank_s2 = lq.bank_s1;
    fd.cnt = fq.cnt + 4'h1;
    case (fq.phase)
      ptic_pkg::PH_ADDR:
      begin
        if (fq.cnt == 4'h0)
          fd.rd = spi_sdi_in;
        else
          fd.addr = cmd_addr;
        if (fq.cnt == `PTIC_FRAME_CMD_LAST)
        begin
          if (fq.rd)
          begin
            fd.phase = ptic_pkg::PH_RDATA;
            fd.shift = pick(cmd_addr, lq.bank_s2);
            fd.sdo = fd.shift[7];
            fd.sdo_oe = 1'b1;
          end
          else
            fd.phase = ptic_pkg::PH_WDATA;
        end
      end
      ptic_pkg::PH_WDATA:
      begin
        fd.shift = {fq.shift[6:0], spi_sdi_in};
        if (fq.cnt == `PTIC_FRAME_DATA_LAST)
        begin
          // Word held stable, toggle announces it to the core
          ld.wr_tog = ~lq.wr_tog;
          ld.wr_addr = fq.addr;
          ld.wr_data = {fq.shift[6:0], spi_sdi_in};
          fd.phase = ptic_pkg::PH_IDLE;
        end
      end
      ptic_pkg::PH_RDATA:
      begin
        fd.shift = {fq.shift[6:0], 1'b0};
        fd.sdo = fq.shift[6];
        if (fq.cnt == `PTIC_FRAME_DATA_LAST)
        begin
          fd.sdo_oe = 1'b0;
          fd.phase = ptic_pkg::PH_IDLE;
        end
      end
      ptic_pkg::PH_IDLE: fd.cnt = fq.cnt; // Extra bits ignored
      default: fd.phase = ptic_pkg::PH_IDLE;
    endcase
  end

  // Frame state ends with chip select; no edge needed after the frame
  always_ff @(posedge spi_clk_in or posedge spi_cs_n_in or posedge rst_async_in)
  begin
    if (spi_cs_n_in || rst_async_in)
      fq <= '0;
    else
      fq <= fd;
  end

  // Persistent link state
  always_ff @(posedge spi_clk_in or posedge rst_async_in)
  begin
    if (rst_async_in)
      lq <= '0;
    else
      lq <= ld;
  end

  assign spi_sdo_out = fq.sdo;
  assign spi_sdo_oe_out = fq.sdo_oe;
  assign wr_tog_out = lq.wr_tog;
  assign wr_addr_out = lq.wr_addr;
  assign wr_data_out = lq.wr_data;

endmodule

/* File: core/ptic_core.sv */
// Threshold and interface control registers with threshold event compare
`include "ptic_defs.svh"

module ptic_core
#(
  parameter int PRESS_W = `PTIC_PRESS_W,
  parameter int PRESS_TO_THS_SHIFT = `PTIC_PRESS_TO_THS_SHIFT
)
(
  input wire logic ref_clk_in,
  input wire logic srst_in,
  input wire logic spi_clk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_sdi_in,
  output logic spi_sdo_out,
  output logic spi_sdo_oe_out,
  input wire logic i3c_active_in,
  input wire logic differential_interrupt_enable_in,
  input wire logic high_event_enable_in,
  input wire logic low_event_enable_in,
  input wire logic sample_valid_in,
  input wire logic signed [PRESS_W-1:0] measured_pressure_in,
  input wire logic signed [PRESS_W-1:0] reference_pressure_in,
  output logic [`PTIC_THS_W-1:0] threshold_value_out,
  output logic signed [PRESS_W-1:0] differential_pressure_out,
  output logic pressure_high_event_out,
  output logic pressure_low_event_out,
  output logic interrupt_pin_out,
  output logic interrupt_pin_oe_out,
  output logic interrupt_pin_pulldown_disable_out,
  output logic sda_pullup_enable_out,
  output logic sdo_pullup_enable_out,
  output logic i3c_disable_out,
  output logic i2c_disable_out
);

  typedef struct packed {
    logic [7:0] ths_low;
    logic [7:0] ths_high;
    logic [7:0] if_ctrl;
    logic tog_s1;
    logic tog_s2;
    logic tog_seen;
    logic signed [PRESS_W-1:0] diff;
    logic diff_valid;
    logic high_ev;
    logic low_ev;
    logic int_val;
    logic int_oe;
  } ptic_core_t;

  ptic_core_t q;
  ptic_core_t d;
  logic wr_tog;
  logic [6:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_fire;
  logic ev_gate;
  logic signed [PRESS_W-1:0] diff_scaled;
  logic signed [PRESS_W-1:0] ths_ext;
  logic high_hit;
  logic low_hit;

  // Link-side serial port; writes come back as toggle plus held word
  ptic_spi_link u_link
  (
    .spi_clk_in(spi_clk_in),
    .rst_async_in(srst_in),
    .spi_cs_n_in(spi_cs_n_in),
    .spi_sdi_in(spi_sdi_in),
    .bank_in({q.if_ctrl, q.ths_high, q.ths_low}),
    .spi_sdo_out(spi_sdo_out),
    .spi_sdo_oe_out(spi_sdo_oe_out),
    .wr_tog_out(wr_tog),
    .wr_addr_out(wr_addr),
    .wr_data_out(wr_data)
  );

  // A write lands once the synced toggle differs from the last one seen
  assign wr_fire = q.tog_s2 != q.tog_seen;

  // Compare terms: pressure LSBs scaled down to threshold LSBs
  assign ev_gate = differential_interrupt_enable_in
                   && (high_event_enable_in || low_event_enable_in);
  assign diff_scaled = q.diff >>> PRESS_TO_THS_SHIFT;
  assign ths_ext = PRESS_W'({q.ths_high[6:0], q.ths_low});
  assign high_hit = diff_scaled > ths_ext;
  assign low_hit = diff_scaled < -ths_ext;

  // Next-state logic, synchronous reset included
  always_comb
  begin
    d = q;
    d.tog_s1 = wr_tog;
    d.tog_s2 = q.tog_s1;
    d.tog_seen = q.tog_s2;
    // Register writes; fixed-zero bits are masked off
    if (wr_fire)
    begin
      case (wr_addr)
        `PTIC_ADDR_THS_LOW: d.ths_low = wr_data;
        `PTIC_ADDR_THS_HIGH: d.ths_high = wr_data & `PTIC_MASK_THS_HIGH;
        `PTIC_ADDR_IF_CTRL: d.if_ctrl = wr_data & `PTIC_MASK_IF_CTRL;
        default: d.ths_low = q.ths_low;
      endcase
    end
    // Differential value taken per sample
    d.diff_valid = sample_valid_in;
    if (sample_valid_in)
      d.diff = PRESS_W'(measured_pressure_in - reference_pressure_in);
    // Events refresh per sample and drop at once when disabled
    if (q.diff_valid)
    begin
      d.high_ev = ev_gate && high_event_enable_in && high_hit;
      d.low_ev = ev_gate && low_event_enable_in && low_hit;
    end
    else
    begin
      d.high_ev = q.high_ev && ev_gate && high_event_enable_in;
      d.low_ev = q.low_ev && ev_gate && low_event_enable_in;
    end
    d.int_val = q.high_ev || q.low_ev;
    // Pin may drive unless I3C runs without the pin enable
    d.int_oe = !i3c_active_in || q.if_ctrl[`PTIC_BIT_INT_EN_I3C];
    if (srst_in)
    begin
      d = '0;
      d.ths_low = `PTIC_RST_THS_LOW;
      d.ths_high = `PTIC_RST_THS_HIGH;
      d.if_ctrl = `PTIC_RST_IF_CTRL;
      // Toggle tracking resumes from the synced level, not a constant
      d.tog_s1 = wr_tog;
      d.tog_s2 = q.tog_s1;
      d.tog_seen = q.tog_s2;
    end
  end

  // State register
  always_ff @(posedge ref_clk_in)
  begin
    q <= d;
  end

  // Outputs straight from state
  assign threshold_value_out = {q.ths_high[6:0], q.ths_low};
  assign differential_pressure_out = q.diff;
  assign pressure_high_event_out = q.high_ev;
  assign pressure_low_event_out = q.low_ev;
  assign interrupt_pin_out = q.int_val;
  assign interrupt_pin_oe_out = q.int_oe;
  assign interrupt_pin_pulldown_disable_out = q.if_ctrl[`PTIC_BIT_INT_PD_DIS];
  assign sda_pullup_enable_out = q.if_ctrl[`PTIC_BIT_SDA_PULLUP_ENABLE];
  assign sdo_pullup_enable_out = q.if_ctrl[`PTIC_BIT_SDO_PULLUP_ENABLE];
  assign i3c_disable_out = q.if_ctrl[`PTIC_BIT_I3C_DIS];
  assign i2c_disable_out = q.if_ctrl[`PTIC_BIT_I2C_DIS];

  // Checks on the core clock
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (srst_in);

  sequence wr_low_s;
    wr_fire && wr_addr == `PTIC_ADDR_THS_LOW;
  endsequence

  sequence wr_high_s;
    wr_fire && wr_addr == `PTIC_ADDR_THS_HIGH;
  endsequence

  sequence wr_ifc_s;
    wr_fire && wr_addr == `PTIC_ADDR_IF_CTRL;
  endsequence

  sequence high_cause_s;
    q.diff_valid && ev_gate && high_event_enable_in && high_hit;
  endsequence

  sequence low_cause_s;
    q.diff_valid && ev_gate && low_event_enable_in && low_hit;
  endsequence

  ths_low_write_a: assert property (wr_low_s |=> q.ths_low == $past(wr_data))
    else $error("low threshold byte missed its write");

  ths_high_write_a: assert property (wr_high_s |=>
    q.ths_high == ($past(wr_data) & `PTIC_MASK_THS_HIGH) && !q.ths_high[7])
    else $error("high threshold byte wrong after write");

  ths_value_hold_a: assert property (!wr_fire |=> $stable(threshold_value_out))
    else $error("threshold value moved without a write");

  event_gate_a: assert property ((pressure_high_event_out || pressure_low_event_out)
    |-> $past(differential_interrupt_enable_in)
        && ($past(high_event_enable_in) || $past(low_event_enable_in)))
    else $error("threshold event while disabled");

  int_pin_oe_a: assert property (!$past(srst_in) |->
    interrupt_pin_oe_out == (!$past(i3c_active_in)
                             || $past(q.if_ctrl[`PTIC_BIT_INT_EN_I3C])))
    else $error("interrupt pin drive enable wrong");

  pullup_write_a: assert property (wr_ifc_s |=>
    sda_pullup_enable_out == $past(wr_data[`PTIC_BIT_SDA_PULLUP_ENABLE])
    && sdo_pullup_enable_out == $past(wr_data[`PTIC_BIT_SDO_PULLUP_ENABLE]))
    else $error("pull-up selects do not follow the write");

  pulldown_write_a: assert property (wr_ifc_s |=>
    interrupt_pin_pulldown_disable_out == $past(wr_data[`PTIC_BIT_INT_PD_DIS]))
    else $error("pull-down select does not follow the write");

  i3c_disable_a: assert property (wr_ifc_s |=>
    i3c_disable_out == $past(wr_data[`PTIC_BIT_I3C_DIS]))
    else $error("I3C disable bit does not follow the write");

  i2c_disable_a: assert property (wr_ifc_s |=>
    i2c_disable_out == $past(wr_data[`PTIC_BIT_I2C_DIS]))
    else $error("I2C disable bit does not follow the write");

  high_event_a: assert property (high_cause_s |=> pressure_high_event_out ##1 interrupt_pin_out)
    else $error("high event not raised");

  low_event_a: assert property (low_cause_s |=> pressure_low_event_out ##1 interrupt_pin_out)
    else $error("low event not raised");

  diff_value_a: assert property (sample_valid_in |=>
    q.diff == PRESS_W'($past(measured_pressure_in) - $past(reference_pressure_in)))
    else $error("differential pressure wrong");

  // Reset values stand on the first edge after release
  reset_values_a: assert property ($past(srst_in) |->
    q.ths_low == `PTIC_RST_THS_LOW && q.ths_high == `PTIC_RST_THS_HIGH
    && q.if_ctrl == `PTIC_RST_IF_CTRL)
    else $error("registers not at reset values after reset");

  reset_outputs_a: assert property ($past(srst_in) |->
    !pressure_high_event_out && !pressure_low_event_out
    && !interrupt_pin_out && !interrupt_pin_oe_out)
    else $error("pin or events up after reset");

  // Fixed-zero bits never read back as one
  masked_bits_a: assert property (!q.ths_high[7] && q.if_ctrl[6:5] == 2'b00)
    else $error("fixed-zero register bits set");

  // A write to one threshold byte leaves the other alone
  low_byte_keep_a: assert property (wr_high_s |=> $stable(q.ths_low))
    else $error("low threshold byte moved on a high byte write");

  high_byte_keep_a: assert property (wr_low_s |=> $stable(q.ths_high))
    else $error("high threshold byte moved on a low byte write");

  // Interface selects change only through their own register
  ifc_hold_a: assert property (!(wr_fire && wr_addr == `PTIC_ADDR_IF_CTRL) |=>
    $stable(q.if_ctrl))
    else $error("interface control moved without a write");

  // Events clear one cycle after the gate closes
  event_drop_a: assert property (!ev_gate |=>
    !pressure_high_event_out && !pressure_low_event_out)
    else $error("event stayed up with interrupts disabled");

  // A disabled direction never raises its own event
  high_off_a: assert property (!high_event_enable_in |=> !pressure_high_event_out)
    else $error("high event without its enable");

  low_off_a: assert property (!low_event_enable_in |=> !pressure_low_event_out)
    else $error("low event without its enable");

  // A fresh sample on the wrong side of the threshold clears the event
  high_clear_a: assert property (q.diff_valid && !high_hit |=> !pressure_high_event_out)
    else $error("high event kept after a sample below threshold");

  low_clear_a: assert property (q.diff_valid && !low_hit |=> !pressure_low_event_out)
    else $error("low event kept after a sample above threshold");

  // Both directions cannot hold at once, the threshold being unsigned
  event_excl_a: assert property (!(pressure_high_event_out && pressure_low_event_out))
    else $error("high and low events both up");

  // Between samples an enabled event holds its level
  sequence high_keep_s;
    !q.diff_valid && ev_gate && high_event_enable_in && pressure_high_event_out;
  endsequence

  sequence low_keep_s;
    !q.diff_valid && ev_gate && low_event_enable_in && pressure_low_event_out;
  endsequence

  high_hold_a: assert property (high_keep_s |=> pressure_high_event_out)
    else $error("high event lost between samples");

  low_hold_a: assert property (low_keep_s |=> pressure_low_event_out)
    else $error("low event lost between samples");

  // The pin shows the OR of both events one cycle later
  int_pin_follow_a: assert property (1'b1 |=>
    interrupt_pin_out == ($past(pressure_high_event_out) || $past(pressure_low_event_out)))
    else $error("interrupt pin does not follow the events");

  // Under I3C without the pin enable the pin stops driving
  int_pin_off_a: assert property (i3c_active_in && !q.if_ctrl[`PTIC_BIT_INT_EN_I3C] |=>
    !interrupt_pin_oe_out)
    else $error("interrupt pin driven under I3C while disabled");

  // Differential value holds until the next sample
  diff_hold_a: assert property (!sample_valid_in |=> $stable(differential_pressure_out))
    else $error("differential pressure moved without a sample");

endmodule

/* File: tb/ptic_host_model.sv */
// Host controller model driving the serial register port in mode 3
module ptic_host_model
(
  output logic spi_clk_out,
  output logic spi_cs_n_out,
  output logic spi_sdi_out,
  input wire logic spi_sdo_in
);
  timeunit 1ns;
  timeprecision 100ps;
  // Frame kind and count of rising edges so far, watched by the bench
  logic frame_rd = 1'b0;
  int edges = 0;

  // Idle levels: clock rests high and chip select is off between frames
  initial
  begin
    spi_clk_out = 1'b1;
    spi_cs_n_out = 1'b1;
    spi_sdi_out = 1'b0;
  end

  // One single-byte frame; slow stretches the low phase of every clock
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdat,
    input int slow, output logic [7:0] rdat);
    logic [15:0] bits;
    bits = {rd, addr, wdat};
    rdat = 8'h00;
    frame_rd = rd;
    edges = 0;
    spi_cs_n_out = 1'b0;
    #6;
    for (int i = 15; i >= 0; i--)
    begin
      spi_clk_out = 1'b0;
      spi_sdi_out = bits[i];
      #(6 + slow);
      // Read bits are taken at the end of the low phase, where they have settled
      if (i < 8)
        rdat[i] = spi_sdo_in;
      spi_clk_out = 1'b1;
      edges++;
      #6;
    end
    spi_cs_n_out = 1'b1;
    spi_sdi_out = ~spi_sdi_out; // Released line shows no stale value
  endtask
endmodule

/* File: tb/tb_top.sv */
// Self-checking bench for the threshold and interface control registers
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic i3c_act = 1'b0;
  logic den = 1'b0;
  logic hen = 1'b0;
  logic len = 1'b0;
  logic smp_vld = 1'b0;
  logic signed [23:0] meas = 24'h000000;
  logic signed [23:0] refp = 24'h000000;
  logic spi_clk, spi_cs_n, spi_sdi, spi_sdo, sdo_oe;
  logic [14:0] thr_out;
  logic signed [23:0] diff_out;
  logic hi_ev, lo_ev, int_pin, int_oe, pd_dis, sda_pu, sdo_pu, i3c_dis, i2c_dis;
  logic [31:0] seed = 32'h0000270f;
  int n_fail = 0;
  int num_checks = 0;
  int mdl[int] = '{8'h0c: 8'h00, 8'h0d: 8'h00, 8'h0e: 8'h00};
  int msk[int] = '{8'h0c: 8'hff, 8'h0d: 8'h7f, 8'h0e: 8'h9f};
  logic [6:0] adr[4] = '{7'h0c, 7'h0d, 7'h0e, 7'h20};

  ptic_core #(.PRESS_W(24), .PRESS_TO_THS_SHIFT(8)) dut
  (
    .ref_clk_in(ref_clk_in),
    .srst_in(srst_in),
    .spi_clk_in(spi_clk),
    .spi_cs_n_in(spi_cs_n),
    .spi_sdi_in(spi_sdi),
    .spi_sdo_out(spi_sdo),
    .spi_sdo_oe_out(sdo_oe),
    .i3c_active_in(i3c_act),
    .differential_interrupt_enable_in(den),
    .high_event_enable_in(hen),
    .low_event_enable_in(len),
    .sample_valid_in(smp_vld),
    .measured_pressure_in(meas),
    .reference_pressure_in(refp),
    .threshold_value_out(thr_out),
    .differential_pressure_out(diff_out),
    .pressure_high_event_out(hi_ev),
    .pressure_low_event_out(lo_ev),
    .interrupt_pin_out(int_pin),
    .interrupt_pin_oe_out(int_oe),
    .interrupt_pin_pulldown_disable_out(pd_dis),
    .sda_pullup_enable_out(sda_pu),
    .sdo_pullup_enable_out(sdo_pu),
    .i3c_disable_out(i3c_dis),
    .i2c_disable_out(i2c_dis)
  );

  ptic_host_model host
  (
    .spi_clk_out(spi_clk),
    .spi_cs_n_out(spi_cs_n),
    .spi_sdi_out(spi_sdi),
    .spi_sdo_in(spi_sdo)
  );

  // Core clock, 25 ns period
  initial
  begin
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  // Xorshift source of random stimulus
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Register write with model update; gap lets the write settle in the core
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input int slow);
    logic [7:0] v;
    host.xfer(1'b0, a, d, slow, v);
    if (msk.exists(a))
      mdl[a] = d & msk[a];
    repeat (12) @(negedge ref_clk_in);
  endtask

  // Register read compared with the model; unmapped places read zero
  task automatic rd(input logic [6:0] a, input int slow);
    logic [7:0] v;
    host.xfer(1'b1, a, 8'h00, slow, v);
    chk(32'(v), msk.exists(a) ? mdl[a] : 0, "read data");
    repeat (2) @(negedge ref_clk_in);
    chk(32'(sdo_oe), 0, "sdo released");
  endtask

  // Link drive enable against the frame position at each falling link edge
  always @(negedge spi_clk)
  begin
    if (!spi_cs_n)
      chk(32'(sdo_oe), 32'(host.frame_rd && host.edges >= 8), "sdo drive");
  end

  // Register-driven outputs against the model
  task automatic chk_outs();
    logic [7:0] c;
    c = 8'(mdl[8'h0e]);
    chk(32'(thr_out), 32'((mdl[8'h0d] % 128) * 256 + mdl[8'h0c]), "threshold");
    chk(32'(sdo_pu), 32'(c[3]), "sdo pull-up");
    chk(32'(sda_pu), 32'(c[4]), "sda pull-up");
    chk(32'(pd_dis), 32'(c[2]), "pull-down off");
    chk(32'(i3c_dis), 32'(c[1]), "i3c off");
    chk(32'(i2c_dis), 32'(c[0]), "i2c off");
    chk(32'(int_oe), 32'(!i3c_act | c[7]), "pin enable");
  endtask

  // Watchdog well beyond the expected run of about 25 us
  initial
  begin
    #300000;
    n_fail++;
    print_verdict();
  end

  // Main sequence
  initial
  begin
    int thr, dd, delta;
    logic [31:0] r;
    logic he_x, le_x;
    repeat (10) @(negedge ref_clk_in);
    srst_in = 1'b0;
    repeat (3) @(negedge ref_clk_in);
    // First pass checks reset values, later passes random writes and read-back
    for (int k = 0; k < 7; k++)
    begin
      i3c_act = 1'(k % 2);
      if (k > 0)
        for (int j = 0; j < 4; j++)
          wr(adr[j], 8'(rnd()) & (j == 2 ? 8'h9f : 8'hff), k % 3);
      for (int j = 0; j < 4; j++)
        rd(adr[j], k % 3);
      chk_outs();
    end
    // Small threshold so that random differences land on both sides
    wr(7'h0c, 8'(rnd()), 0);
    wr(7'h0d, 8'(rnd()) & 8'h01, 0);
    thr = (mdl[8'h0d] % 128) * 256 + mdl[8'h0c];
    // Every enable combination against random and boundary differences
    for (int k = 0; k < 32; k++)
    begin
      r = rnd();
      case (k % 4)
        0: delta = int'($signed(r[18:0]));
        1: delta = thr * 256;
        2: delta = thr * 256 + 256;
        default: delta = -thr * 256 - 256;
      endcase
      dd = delta >>> 8;
      {den, hen, len} = 3'(k / 4);
      he_x = den & hen & (dd > thr);
      le_x = den & len & (dd < -thr);
      i3c_act = r[20];
      smp_vld = 1'b1;
      meas = 24'($signed(r[31:11]));
      refp = meas - 24'(delta);
      @(negedge ref_clk_in);
      smp_vld = 1'b0;
      repeat (4) @(negedge ref_clk_in);
      chk(32'(diff_out), 32'(24'(delta)), "difference");
      chk(32'(hi_ev), 32'(he_x), "high event");
      chk(32'(lo_ev), 32'(le_x), "low event");
      chk(32'(int_pin), 32'(he_x | le_x), "interrupt pin");
      chk_outs();
    end
    // Reset in mid-run returns registers and events to their reset values
    srst_in = 1'b1;
    repeat (10) @(negedge ref_clk_in);
    srst_in = 1'b0;
    foreach (mdl[a])
      mdl[a] = 0;
    repeat (3) @(negedge ref_clk_in);
    chk(32'(hi_ev), 0, "high event after reset");
    chk(32'(lo_ev), 0, "low event after reset");
    chk(32'(int_pin), 0, "pin after reset");
    for (int j = 0; j < 4; j++)
      rd(adr[j], 0);
    chk_outs();
    print_verdict();
  end
endmodule
